/* File: core/adc_conversion_ctl.sv */
// Conversion sequencer, control registers and capture path of the ADC
//
// Summary of operation
// - Single-shot and continuous runs start by software or by the pin.
// - Capture mode converts and stores samples to memory unattended.
// - Factory offset and gain values load into calibration at power-up.
// - Software may overwrite both calibration registers afterwards.
// - Temperature reference is selectable as a ninth input channel.
// - Results are straight binary, full scale split into 4096 codes.
// - Result split over two bytes; high byte top nibble carries channel.
// - Power field: off, normal, off when idle, standby when idle.
// - Reference stays on while everything else is powered down.
// - Converter clock is master clock divided by 1, 2, 4 or 8.
// - Each conversion spends 17 converter clock periods.
// - Acquisition lasts 1, 2, 4 or 8 converter clock periods.
// - Timer overflows trigger when enabled, on every second overflow.
// - Pin trigger enabled: low pulse on start pin begins conversion.
// - Done flag set on conversion end outside capture mode or on block end, cleared on vector.
// - Single-shot bit starts one conversion and clears when done.
// - Continuous bit restarts a conversion after each completion.
// - Channel bits choose channel; capture mode takes memory's ID.
`timescale 1ns/100ps
module adc_conversion_ctl
   import adc_ctl_pkg::*;
#(
   parameter int ADDR_BITS = DMA_ADDR_BITS,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_WE,
   input wire logic SFR_RE,
   output logic [7:0] SFR_RDATA,
   input wire logic TIMER2_OVF,
   input wire logic CONVERT_START_PIN_N,
   input wire logic COMPARATOR,
   input wire logic [7:0] FACTORY_OFFSET,
   input wire logic [7:0] FACTORY_GAIN,
   input wire logic IRQ_ACK,
   input wire logic [CHAN_BITS-1:0] DMA_CHAN_ID,
   input wire logic MEM_READY,
   output logic MEM_VALID,
   output logic [ADDR_BITS-1:0] MEM_ADDR,
   output logic [DMA_WORD_BITS-1:0] MEM_WDATA,
   output logic CONVERSION_DONE_FLAG,
   output logic ANALOG_ON,
   output logic REF_ON,
   output logic STANDBY,
   output logic TRACK,
   output logic [RES_BITS-1:0] DAC_CODE,
   output logic [CHAN_BITS-1:0] MUX_SEL,
   output logic TEMP_SEL,
   output logic [7:0] CAL_OFFSET,
   output logic [7:0] CAL_GAIN
);
   seq_state_e state_ff;
   logic [7:0] timing_ff;
   logic flag_ff;
   logic dma_ff;
   logic cont_ff;
   logic single_ff;
   logic [CHAN_BITS-1:0] chan_ff;
   logic [7:0] result_high_ff;
   logic [7:0] result_low_ff;
   logic cal_loaded_ff;
   logic [2:0] div_cnt_ff;
   logic [2:0] acq_cnt_ff;
   logic [4:0] conv_cnt_ff;
   logic [RES_BITS-1:0] nxt_dac;
   logic [CHAN_BITS-1:0] conv_chan_ff;
   logic pin_s1_ff;
   logic pin_s2_ff;
   logic pin_s3_ff;
   logic pin_level_ff;
   logic t2_half_ff;
   logic [ADDR_BITS-1:0] addr_ff;
   logic wr_start;
   logic wr_timing;
   logic [1:0] mode;
   logic [2:0] div_max;
   logic [2:0] acq_max;
   logic adc_tick;
   logic pin_go;
   logic timer_go;
   logic busy;
   logic start;
   logic dma_end;
   logic conv_start;
   logic done;
   logic [3:0] bit_idx;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [DMA_WORD_BITS-1:0] fifo_out_data;
   logic push;

   ////////////////////////////////////////////////////////////////////////
   // Decode and field views
   assign wr_start = CE && SFR_WE && SFR_ADDR == ADDR_CHAN_START;
   assign wr_timing = CE && SFR_WE && SFR_ADDR == ADDR_TIMING_POWER;
   assign mode = timing_ff[MODE_HI:MODE_LO];
   assign div_max = 3'((4'h1 << timing_ff[CLKDIV_HI:CLKDIV_LO]) - 4'h1);
   assign acq_max = 3'((4'h1 << timing_ff[ACQ_HI:ACQ_LO]) - 4'h1);
   assign adc_tick = CE && div_cnt_ff == div_max;
   assign busy = state_ff != ST_IDLE;
   assign done = CE && state_ff == ST_DONE;

   ////////////////////////////////////////////////////////////////////////
   // Start pin synchroniser and falling edge
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         pin_s1_ff <= 1'b1;
         pin_s2_ff <= 1'b1;
         pin_s3_ff <= 1'b1;
         pin_level_ff <= 1'b1;
      end else if (CE) begin
         pin_s1_ff <= CONVERT_START_PIN_N;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         if (pin_s2_ff == pin_s3_ff) begin
            pin_level_ff <= pin_s2_ff;
         end
      end
   end

   // One start per low pulse
   assign pin_go = timing_ff[PIN_BIT] && pin_level_ff &&
                   pin_s2_ff == pin_s3_ff && !pin_s2_ff;

   ////////////////////////////////////////////////////////////////////////
   // Timer trigger, every second overflow
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         t2_half_ff <= 1'b0;
      end else if (CE) begin
         if (!timing_ff[TIMER_BIT]) begin
            t2_half_ff <= 1'b0;
         end else if (TIMER2_OVF) begin
            t2_half_ff <= !t2_half_ff;
         end
      end
   end

   assign timer_go = timing_ff[TIMER_BIT] && TIMER2_OVF && t2_half_ff;

   ////////////////////////////////////////////////////////////////////////
   // Start arbitration
   assign start = CE && !busy && mode != MODE_OFF && cal_loaded_ff &&
                  (single_ff || cont_ff || dma_ff ||
                   timer_go || pin_go) &&
                  !(dma_ff && !fifo_in_ready);
   assign dma_end = start && dma_ff && DMA_CHAN_ID == DMA_END_ID;
   assign conv_start = start && !dma_end;

   ////////////////////////////////////////////////////////////////////////
   // Converter clock divider
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         div_cnt_ff <= 3'h0;
      end else if (CE) begin
         if (adc_tick || !busy) begin
            div_cnt_ff <= 3'h0;
         end else begin
            div_cnt_ff <= div_cnt_ff + 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         state_ff <= ST_IDLE;
         acq_cnt_ff <= 3'h0;
         conv_cnt_ff <= 5'h0;
      end else if (CE) begin
         case (state_ff)
            ST_IDLE: begin
               acq_cnt_ff <= 3'h0;
               conv_cnt_ff <= 5'h0;
               if (conv_start) begin
                  state_ff <= ST_ACQ;
               end
            end
            ST_ACQ: begin
               if (adc_tick) begin
                  if (acq_cnt_ff == acq_max) begin
                     state_ff <= ST_CONV;
                  end else begin
                     acq_cnt_ff <= acq_cnt_ff + 3'h1;
                  end
               end
            end
            ST_CONV: begin
               if (adc_tick) begin
                  if (conv_cnt_ff == CONV_CLKS - 5'h1) begin
                     state_ff <= ST_DONE;
                  end else begin
                     conv_cnt_ff <= conv_cnt_ff + 5'h1;
                  end
               end
            end
            ST_DONE: begin
               state_ff <= ST_IDLE;
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Successive approximation, straight binary code
   assign bit_idx = 4'(RES_BITS - 1) - conv_cnt_ff[3:0];

   always_comb begin
      nxt_dac = DAC_CODE;
      if (state_ff == ST_ACQ && adc_tick && acq_cnt_ff == acq_max) begin
         nxt_dac = {1'b1, {(RES_BITS - 1){1'b0}}};
      end else if (state_ff == ST_CONV && adc_tick &&
                   conv_cnt_ff < 5'(RES_BITS)) begin
         nxt_dac[bit_idx] = COMPARATOR;
         if (bit_idx != 4'h0) begin
            nxt_dac[bit_idx - 4'h1] = 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         DAC_CODE <= '0;
         TRACK <= 1'b0;
      end else if (CE) begin
         DAC_CODE <= nxt_dac;
         TRACK <= conv_start || (state_ff == ST_ACQ &&
                  !(adc_tick && acq_cnt_ff == acq_max));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel selection
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         conv_chan_ff <= '0;
         MUX_SEL <= '0;
         TEMP_SEL <= 1'b0;
      end else if (CE && conv_start) begin
         conv_chan_ff <= dma_ff ? DMA_CHAN_ID : chan_ff;
         MUX_SEL <= dma_ff ? DMA_CHAN_ID : chan_ff;
         TEMP_SEL <= (dma_ff ? DMA_CHAN_ID : chan_ff) == TEMP_CHANNEL;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power control
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         ANALOG_ON <= 1'b0;
         STANDBY <= 1'b0;
         REF_ON <= 1'b1;
      end else if (CE) begin
         ANALOG_ON <= mode == MODE_NORMAL || (mode[1] && busy);
         STANDBY <= mode == MODE_AUTO_STBY && !busy;
         REF_ON <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Timing and power register
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         timing_ff <= RST_TIMING_POWER;
      end else if (wr_timing) begin
         timing_ff <= SFR_WDATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel and start register
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         flag_ff <= RST_CHAN_START[FLAG_BIT];
         dma_ff <= RST_CHAN_START[DMA_BIT];
         cont_ff <= RST_CHAN_START[CONT_BIT];
         single_ff <= RST_CHAN_START[SINGLE_BIT];
         chan_ff <= RST_CHAN_START[CHAN_HI:CHAN_LO];
      end else if (CE) begin
         if ((done && !dma_ff) || dma_end) begin
            flag_ff <= 1'b1;
         end else if (wr_start) begin
            flag_ff <= SFR_WDATA[FLAG_BIT];
         end else if (IRQ_ACK) begin
            flag_ff <= 1'b0;
         end
         if (wr_start) begin
            dma_ff <= SFR_WDATA[DMA_BIT];
            cont_ff <= SFR_WDATA[CONT_BIT];
            chan_ff <= SFR_WDATA[CHAN_HI:CHAN_LO];
         end else if (dma_end) begin
            dma_ff <= 1'b0;
         end
         if (wr_start && SFR_WDATA[SINGLE_BIT]) begin
            single_ff <= 1'b1;
         end else if (wr_start) begin
            single_ff <= 1'b0;
         end else if (done) begin
            single_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result registers with channel tag
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         result_high_ff <= 8'h00;
         result_low_ff <= 8'h00;
      end else if (done) begin
         result_high_ff <= {conv_chan_ff, DAC_CODE[RES_BITS-1:8]};
         result_low_ff <= DAC_CODE[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Calibration coefficients
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         cal_loaded_ff <= 1'b0;
         CAL_OFFSET <= 8'h00;
         CAL_GAIN <= 8'h00;
      end else if (CE) begin
         cal_loaded_ff <= 1'b1;
         if (!cal_loaded_ff) begin
            CAL_OFFSET <= FACTORY_OFFSET;
            CAL_GAIN <= FACTORY_GAIN;
         end else if (SFR_WE && SFR_ADDR == ADDR_CAL_OFFSET) begin
            CAL_OFFSET <= SFR_WDATA;
         end else if (SFR_WE && SFR_ADDR == ADDR_CAL_GAIN) begin
            CAL_GAIN <= SFR_WDATA;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register read port
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         SFR_RDATA <= RD_UNMAPPED;
      end else if (CE && SFR_RE) begin
         case (SFR_ADDR)
            ADDR_CHAN_START: begin
               SFR_RDATA <= {flag_ff, dma_ff, cont_ff, single_ff, chan_ff};
            end
            ADDR_TIMING_POWER: begin
               SFR_RDATA <= timing_ff;
            end
            ADDR_RESULT_HIGH: begin
               SFR_RDATA <= result_high_ff;
            end
            ADDR_RESULT_LOW: begin
               SFR_RDATA <= result_low_ff;
            end
            ADDR_CAL_OFFSET: begin
               SFR_RDATA <= CAL_OFFSET;
            end
            ADDR_CAL_GAIN: begin
               SFR_RDATA <= CAL_GAIN;
            end
            default: begin
               SFR_RDATA <= RD_UNMAPPED;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         CONVERSION_DONE_FLAG <= 1'b0;
      end else if (CE) begin
         CONVERSION_DONE_FLAG <= flag_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture path to external memory
   assign push = done && dma_ff;

   sample_fifo #(
      .WIDTH(DMA_WORD_BITS),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(CLOCK),
      .rst_n(RSTN),
      .en(CE),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data({conv_chan_ff, DAC_CODE}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   assign fifo_out_ready = !MEM_VALID || MEM_READY;

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         MEM_VALID <= 1'b0;
         MEM_WDATA <= '0;
         MEM_ADDR <= '0;
         addr_ff <= '0;
      end else if (CE) begin
         if (fifo_out_ready) begin
            MEM_VALID <= fifo_out_valid;
            if (fifo_out_valid) begin
               MEM_WDATA <= fifo_out_data;
               MEM_ADDR <= addr_ff;
            end
         end
         if (wr_start && SFR_WDATA[DMA_BIT] && !dma_ff) begin
            addr_ff <= '0;
         end else if (fifo_out_ready && fifo_out_valid) begin
            addr_ff <= addr_ff + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);

   a_single_bit_clear: assert property (
      done && !wr_start |=> !single_ff)
      else $error("single-shot bit not cleared at completion");
   a_result_chan_tag: assert property (
      done |=> result_high_ff[7:4] == $past(conv_chan_ff))
      else $error("result high byte lacks channel tag");
   a_done_flag_set: assert property (
      done && !dma_ff |=> flag_ff)
      else $error("done flag not set after conversion");
   a_busy_ignore_trig: assert property (
      state_ff == ST_CONV && (pin_go || timer_go) |-> !conv_start)
      else $error("trigger accepted during conversion");
   a_div_eight_gap: assert property (
      adc_tick && timing_ff[CLKDIV_HI:CLKDIV_LO] == 2'b11 && busy
      && !wr_timing |=> !adc_tick [*7])
      else $error("divide by eight tick spacing wrong");
   a_conv_count_bound: assert property (
      state_ff == ST_CONV |-> conv_cnt_ff < CONV_CLKS)
      else $error("conversion count exceeds 17 clocks");
   a_acq_count_bound: assert property (
      state_ff == ST_ACQ |-> acq_cnt_ff <= acq_max)
      else $error("acquisition count exceeds selection");
   a_power_off_mode: assert property (
      CE && mode == MODE_OFF |=> !ANALOG_ON && !STANDBY)
      else $error("analog powered in power-down mode");
   a_ref_stays_on: assert property (
      CE && mode == MODE_OFF |=> REF_ON)
      else $error("reference off in power-down mode");
   a_timer_second_ovf: assert property (
      timer_go |-> t2_half_ff && $past(timing_ff[TIMER_BIT]))
      else $error("timer start on first overflow");
   a_cal_factory_load: assert property (
      CE && !cal_loaded_ff |=> CAL_OFFSET == $past(FACTORY_OFFSET)
      && CAL_GAIN == $past(FACTORY_GAIN))
      else $error("factory calibration not loaded");

   c_single_done: cover property (single_ff && done);
   c_pin_start: cover property (pin_go && conv_start);
   c_dma_block_end: cover property (dma_end);
   c_fifo_stall: cover property (dma_ff && !fifo_in_ready);
endmodule : adc_conversion_ctl

/* File: core/adc_ctl_pkg.sv */
// Constants, field layout and state codes of the conversion control
package adc_ctl_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Register addresses
   localparam logic [7:0] ADDR_CHAN_START = 8'hd8;
   localparam logic [7:0] ADDR_TIMING_POWER = 8'hef;
   localparam logic [7:0] ADDR_RESULT_LOW = 8'hd9;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'hda;
   localparam logic [7:0] ADDR_CAL_OFFSET = 8'hf1;
   localparam logic [7:0] ADDR_CAL_GAIN = 8'hf3;
   localparam logic [7:0] RST_CHAN_START = 8'h00;
   localparam logic [7:0] RST_TIMING_POWER = 8'h20;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   ////////////////////////////////////////////////////////////////////////
   // Channel and start control fields
   localparam int FLAG_BIT = 7;
   localparam int DMA_BIT = 6;
   localparam int CONT_BIT = 5;
   localparam int SINGLE_BIT = 4;
   localparam int CHAN_HI = 3;
   localparam int CHAN_LO = 0;
   ////////////////////////////////////////////////////////////////////////
   // Timing and power control fields
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 6;
   localparam int CLKDIV_HI = 5;
   localparam int CLKDIV_LO = 4;
   localparam int ACQ_HI = 3;
   localparam int ACQ_LO = 2;
   localparam int TIMER_BIT = 1;
   localparam int PIN_BIT = 0;
   localparam logic [1:0] MODE_OFF = 2'b00;
   localparam logic [1:0] MODE_NORMAL = 2'b01;
   localparam logic [1:0] MODE_AUTO_OFF = 2'b10;
   localparam logic [1:0] MODE_AUTO_STBY = 2'b11;
   ////////////////////////////////////////////////////////////////////////
   // Conversion figures
   localparam int RES_CODES = 4096;
   localparam int RES_BITS = $clog2(RES_CODES);
   localparam int CHAN_BITS = 4;
   localparam logic [4:0] CONV_CLKS = 5'd17;
   localparam logic [3:0] TEMP_CHANNEL = 4'h8;
   localparam logic [3:0] DMA_END_ID = 4'hf;
   localparam int DMA_ADDR_BITS = 24;
   localparam int DMA_WORD_BITS = CHAN_BITS + RES_BITS;
   localparam int FIFO_DEPTH = 16;
   ////////////////////////////////////////////////////////////////////////
   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACQ = 2'b01,
      ST_CONV = 2'b10,
      ST_DONE = 2'b11
   } seq_state_e;
endpackage : adc_ctl_pkg

/* File: core/sample_fifo.sv */
// Flip-flop FIFO between conversion results and the memory writer
`timescale 1ns/100ps
module sample_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ptr_ff;
   logic [AW:0] rd_ptr_ff;
   logic push;
   logic pop;
   logic full;
   logic empty;

   ////////////////////////////////////////////////////////////////////////
   // Status
   assign empty = wr_ptr_ff == rd_ptr_ff;
   assign full = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) &&
                 (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];
   assign push = en && in_valid && !full;
   assign pop = en && out_ready && !empty;

   ////////////////////////////////////////////////////////////////////////
   // Storage and pointers
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
      end
   end

   a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rst_n)
      full && en && in_valid |=> $stable(wr_ptr_ff))
      else $error("fifo pointer moved while full");
endmodule : sample_fifo

/* File: verif/far_side_model.sv */
// Analog input and capture memory stand-in
`timescale 1ns/100ps
module far_side_model
   import adc_ctl_pkg::*;
(
   input wire logic clk,
   input wire logic [RES_BITS-1:0] level,
   input wire logic [RES_BITS-1:0] dac_code,
   output logic comp,
   input wire logic mem_valid,
   output logic mem_ready
);
   // Comparator high when input at or above trial code
   assign comp = (level >= dac_code);
   // Memory stalls every other cycle
   initial mem_ready = 1'b0;
   always @(posedge clk) begin
      mem_ready <= ~mem_ready;
   end
endmodule : far_side_model

/* File: verif/tb_adc_conversion_ctl.sv */
// Self-checking bench of the conversion control
`timescale 1ns/100ps
module tb_adc_conversion_ctl
   import adc_ctl_pkg::*;
;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic we = 1'b0, re = 1'b0, pin_n = 1'b1, ovf = 1'b0, ack = 1'b0;
   logic comp, mrdy, mval, flag, ref_on, an_on, tsel;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, cal_o;
   logic [11:0] level = 12'h5a3, dac;
   logic [7:0] v;
   logic [3:0] dma_id = 4'h2;
   logic [15:0] mwd;
   logic [23:0] maddr;
   int n_errors = 0, n_compared = 0, cyc;
   always #2.5 clock = ~clock;
   adc_conversion_ctl adc_conversion_ctl_inst (.CLOCK(clock), .RSTN(rstn),
      .CE(1'b1), .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WE(we),
      .SFR_RE(re), .SFR_RDATA(rdata), .TIMER2_OVF(ovf),
      .CONVERT_START_PIN_N(pin_n), .COMPARATOR(comp),
      .FACTORY_OFFSET(8'h3c), .FACTORY_GAIN(8'hc5), .IRQ_ACK(ack),
      .DMA_CHAN_ID(dma_id), .MEM_READY(mrdy), .MEM_VALID(mval),
      .MEM_ADDR(maddr), .MEM_WDATA(mwd), .CONVERSION_DONE_FLAG(flag),
      .ANALOG_ON(an_on),
      .REF_ON(ref_on), .STANDBY(), .TRACK(), .DAC_CODE(dac), .MUX_SEL(),
      .TEMP_SEL(tsel), .CAL_OFFSET(cal_o), .CAL_GAIN());
   far_side_model far_side_model_inst (.clk(clock), .level(level),
      .dac_code(dac), .comp(comp), .mem_valid(mval), .mem_ready(mrdy));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock) {addr, wdata, we} = {a, d, 1'b1};
      @(negedge clock) we = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock) {addr, re} = {a, 1'b1};
      @(negedge clock) re = 1'b0;
      d = rdata;
   endtask : rd
   task automatic wait_flag(output int c);
      logic [7:0] f;
      c = 0;
      f = 8'h00;
      while (f[7] !== 1'b1 && c < 900) begin
         rd(8'hd8, f);
         c += 2;
      end
      v = f;
   endtask : wait_flag
   task automatic pulse(ref logic s, input logic lvl, input int n);
      @(negedge clock) s = lvl;
      repeat (n) @(negedge clock);
      s = ~lvl;
   endtask : pulse
   task automatic summarize();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(8'hef, v); chk("timing reset", 8'h20, v);
      rd(8'hd8, v); chk("start reset", 8'h00, v);
      rd(8'h00, v); chk("unmapped", 8'h00, v);
      chk("factory offset", 8'h3c, cal_o);
      chk("ref on", 8'h01, {7'h0, ref_on});
      wr(8'hf1, 8'h55); rd(8'hf1, v); chk("user offset", 8'h55, v);
   endtask : t_reset
   task automatic t_single();
      wr(8'hef, 8'h40); wr(8'hd8, 8'h13); wait_flag(cyc);
      chk("single cleared", 8'h83, v);
      rd(8'hd8, v); chk("single cleared", 8'h83, v);
      chk("flag port", 8'h01, {7'h0, flag});
      rd(8'hda, v); chk("result high", 8'h35, v);
      rd(8'hd9, v); chk("result low", 8'ha3, v);
      pulse(ack, 1'b1, 1); rd(8'hd8, v); chk("ack", 8'h03, v);
      wr(8'hef, 8'h00); level = 12'h111; wr(8'hd8, 8'h12);
      repeat (60) @(negedge clock);
      chk("off", 8'h00, {7'h0, an_on});
      rd(8'hda, v); chk("off result", 8'h35, v);
      wr(8'hd8, 8'h00);
   endtask : t_single
   task automatic t_pin_timer();
      wr(8'hef, 8'h41); wr(8'hd8, 8'h08);
      pulse(pin_n, 1'b0, 30); wait_flag(cyc);
      chk("temp sel", 8'h01, {7'h0, tsel});
      rd(8'hda, v); chk("temp result", 8'h81, v);
      pulse(ack, 1'b1, 1); wr(8'hef, 8'h42);
      pulse(ovf, 1'b1, 1); repeat (40) @(negedge clock);
      rd(8'hd8, v); chk("first overflow", 8'h08, v);
      pulse(ovf, 1'b1, 1); wait_flag(cyc);
      chk("second overflow", 8'h88, v);
      pulse(ack, 1'b1, 1);
   endtask : t_pin_timer
   task automatic t_dma();
      wr(8'hef, 8'h40); wr(8'hd8, 8'h40);
      cyc = 0;
      while (mval !== 1'b1 && cyc < 200) begin
         @(negedge clock);
         cyc++;
      end
      chk("dma word high", 8'h21, mwd[15:8]);
      chk("dma word low", 8'h11, mwd[7:0]);
      chk("dma address", 8'h00, maddr[7:0]);
      @(negedge clock) dma_id = 4'hf;
      wait_flag(cyc);
      chk("dma block end", 8'h80, v);
      pulse(ack, 1'b1, 1);
   endtask : t_dma
   task automatic t_cont();
      wr(8'hef, 8'h7c); wr(8'hd8, 8'h21); wait_flag(cyc);
      chk("slow timing", 8'h01, {7'h0, cyc >= 196});
      pulse(ack, 1'b1, 1); wait_flag(cyc);
      chk("restart", 8'ha1, v);
      wr(8'hd8, 8'h00);
   endtask : t_cont
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(negedge clock);
      rstn = 1'b1;
      repeat (3) @(negedge clock);
      t_reset();
      t_single();
      t_pin_timer();
      t_dma();
      t_cont();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      summarize();
   end
endmodule : tb_adc_conversion_ctl
